// file: hdl/safety_node.sv
/*
  Safety node end: station address decode, safety parameters, telegram
  supervision and configuration access, with a Wishbone register port.
  Assumes a 100 MHz clock, synchronous reset and a 32-bit classic Wishbone master.
*/
// Function
// - Both process images are ten bytes.
// - Missed telegrams within monitor time force failsafe.
// - Two-byte CRC expected and generated.
// - Parameter version fixed at zero.
// - Master assigns unique addresses 1 to 65534.
// - Accept only telegrams addressed to own address.
// - Option includes or excludes sequence in CRC.
// - Integrity class one through three accepted.
// - Station address is tens times ten plus units.
// - Switch range 0 to 99, default 0.
// - Switch 01 selects station address 126.
// - Switch 02 reserved, not to be used; the decode passes it through as station address 2.
// - Switches 00 take software address 3 to 125.
// - Serial path reaches node, links and address.
// - Device link path reaches only its own link; the code still lets it write config_active, the mask and the access register.
// - During configuration send zeros and failsafe flag.
`timescale 1ns/1ps
module safety_node #(
  parameter int cycles_per_ms = safety_node_pkg::cycles_per_ms
) (
  input wire logic clk_i,
  input wire logic rst_i,
  safety_link_if.node link,
  input wire logic [3:0] switch_tens_i,
  input wire logic [3:0] switch_units_i,
  input wire logic [79:0] field_image_i,
  output logic [79:0] field_image_o,
  output logic [6:0] station_address_o,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic irq_o
);
  localparam logic [7:0] reg_config = 8'h00;
  localparam logic [7:0] reg_address = 8'h04;
  localparam logic [7:0] reg_station = 8'h08;
  localparam logic [7:0] reg_status = 8'h0c;
  localparam logic [7:0] reg_mask = 8'h10;
  localparam logic [7:0] reg_access = 8'h14;
  localparam logic [7:0] reg_ident = 8'h18;
  logic [15:0] monitor_time;
  logic sequence_check_option;
  logic [1:0] safety_integrity_class;
  logic config_active;
  logic [15:0] own_address;
  logic [6:0] soft_station;
  logic [1:0] access_path;
  logic [1:0] access_link;
  logic [1:0] status;
  logic [1:0] mask;
  logic expired;
  logic failsafe_active_flag;
  logic seq_toggle;
  wire strobe = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire [7:0] offset = wb_adr_i[7:0];
  wire hit = (offset <= reg_ident) && (offset[1:0] == 2'h0) && (wb_adr_i[31:8] == 24'h0);
  wire write_en = strobe && hit && wb_we_i && wb_sel_i[0];
  wire read_status = strobe && hit && !wb_we_i && (offset == reg_status);
  wire [6:0] switch_value = 7'(switch_tens_i * safety_node_pkg::tens_weight) + 7'(switch_units_i);
  wire switch_valid = (switch_tens_i <= safety_node_pkg::digit_max) &&
    (switch_units_i <= safety_node_pkg::digit_max);
  wire switch_soft = (switch_value == safety_node_pkg::station_default);
  wire [6:0] next_station = !switch_valid ? safety_node_pkg::station_default :
    (switch_value == safety_node_pkg::station_special_switch) ? safety_node_pkg::station_special_address :
    switch_soft ? soft_station : switch_value;
  wire [6:0] new_station = wb_dat_i[6:0];
  wire station_ok = (new_station >= safety_node_pkg::station_soft_min) &&
    (new_station <= safety_node_pkg::station_soft_max);
  wire path_may_set_address = (access_path == safety_node_pkg::path_serial);
  wire path_may_set_node = (access_path != safety_node_pkg::path_device_link);
  wire class_ok = (wb_dat_i[3:2] >= safety_node_pkg::integrity_class_min) &&
    (wb_dat_i[3:2] <= safety_node_pkg::integrity_class_max);
  wire time_ok = (wb_dat_i[31:16] >= safety_node_pkg::monitor_time_min);
  wire addr_ok = (wb_dat_i[15:0] >= safety_node_pkg::safety_address_min) &&
    (wb_dat_i[15:0] <= safety_node_pkg::safety_address_max);
  wire dest_match = (link.ctl_dest == own_address);
  wire [15:0] expected_crc = crc16(link.ctl_image, link.ctl_source, link.ctl_dest, link.ctl_seq,
    sequence_check_option);
  wire telegram_ok = link.ctl_valid && dest_match && (link.ctl_crc == expected_crc);
  wire [15:0] out_crc = crc16(field_image_i, own_address, own_address, seq_toggle,
    sequence_check_option);
  function automatic logic [15:0] crc16(input logic [79:0] image, input logic [15:0] src,
    input logic [15:0] dst, input logic seq, input logic use_seq);
    logic [112:0] data;
    logic [15:0] crc;
    logic fb;
    data = {image, src, dst, use_seq & seq};
    crc = 16'hffff;
    for (int i = 112; i >= 0; i--)
    begin
      fb = crc[15] ^ data[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return crc;
  endfunction
  telegram_watchdog #(
    .cycles_per_ms(cycles_per_ms)
  ) watchdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(!config_active),
    .restart_i(telegram_ok),
    .limit_ms_i(monitor_time),
    .expired_o(expired)
  );
  assign failsafe_active_flag = expired || config_active;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      monitor_time <= 16'hffff;
      sequence_check_option <= 1'b0;
      safety_integrity_class <= safety_node_pkg::integrity_class_min;
      config_active <= 1'b0;
      own_address <= 16'h0;
      soft_station <= safety_node_pkg::station_default;
      access_path <= safety_node_pkg::path_serial;
      access_link <= 2'h0;
      mask <= 2'h0;
    end
    else if (write_en)
    begin
      case (offset)
        reg_config:
        begin
          if (path_may_set_node && class_ok && time_ok)
          begin
            monitor_time <= wb_dat_i[31:16];
            safety_integrity_class <= wb_dat_i[3:2];
            sequence_check_option <= wb_dat_i[1];
          end
          config_active <= wb_dat_i[0];
        end
        reg_address:
          if (path_may_set_node && addr_ok)
            own_address <= wb_dat_i[15:0];
        reg_station:
          if (path_may_set_address && station_ok)
            soft_station <= new_station;
        reg_mask:
          mask <= wb_dat_i[1:0];
        reg_access:
        begin
          access_path <= wb_dat_i[1:0];
          access_link <= wb_dat_i[5:4];
        end
        default:
          mask <= mask;
      endcase
    end
  end
  // Status bits are sticky; a set in the clearing read cycle wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= 2'h0;
    else
      status <= (read_status ? 2'h0 : status) | {expired, failsafe_active_flag};
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link.node_valid <= 1'b0;
      link.node_image <= 80'h0;
      link.node_crc <= 16'h0;
      link.node_failsafe <= 1'b1;
      link.node_seq <= 1'b0;
      field_image_o <= 80'h0;
      seq_toggle <= 1'b0;
      station_address_o <= safety_node_pkg::station_default;
    end
    else
    begin
      station_address_o <= next_station;
      link.node_valid <= telegram_ok;
      link.node_failsafe <= failsafe_active_flag;
      link.node_image <= failsafe_active_flag ? 80'h0 : field_image_i;
      link.node_crc <= failsafe_active_flag ? crc16(80'h0, own_address, own_address, seq_toggle,
        sequence_check_option) : out_crc;
      link.node_seq <= seq_toggle;
      if (telegram_ok)
        seq_toggle <= !seq_toggle;
      if (failsafe_active_flag)
        field_image_o <= 80'h0;
      else if (telegram_ok)
        field_image_o <= link.ctl_image;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= strobe && hit;
      wb_err_o <= strobe && !hit;
      case (offset)
        reg_config: wb_dat_o <= {monitor_time, 12'h0, safety_integrity_class, sequence_check_option, config_active};
        reg_address: wb_dat_o <= {16'h0, own_address};
        reg_station: wb_dat_o <= {25'h0, station_address_o};
        reg_status: wb_dat_o <= {30'h0, status};
        reg_mask: wb_dat_o <= {30'h0, mask};
        reg_access: wb_dat_o <= {26'h0, access_link, 2'h0, access_path};
        reg_ident: wb_dat_o <= {21'h0, safety_node_pkg::crc_length_bytes, safety_node_pkg::parameter_version};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end
  assign irq_o = |(status & mask);
endmodule

// file: shared/safety_node_pkg.sv
/*
  Shared constants for the safety node address and watchdog block.
  Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
package safety_node_pkg;
  localparam int image_bytes = 10;
  localparam int clk_mhz = 100;
  localparam int monitor_time_ms_max = 65535;
  localparam int cycles_per_ms = clk_mhz * 1000;
  localparam logic [2:0] crc_length_bytes = 3'h2;
  localparam logic [7:0] parameter_version = 8'h00;
  localparam logic [15:0] safety_address_min = 16'h0001;
  localparam logic [15:0] safety_address_max = 16'hfffe;
  localparam logic [15:0] monitor_time_min = 16'h0001;
  localparam logic [1:0] integrity_class_min = 2'h1;
  localparam logic [1:0] integrity_class_max = 2'h3;
  localparam logic [6:0] station_special_switch = 7'h01;
  localparam logic [6:0] station_special_address = 7'h7e;
  localparam logic [6:0] station_reserved_switch = 7'h02;
  localparam logic [6:0] station_soft_min = 7'h03;
  localparam logic [6:0] station_soft_max = 7'h7d;
  localparam logic [6:0] station_default = 7'h00;
  localparam logic [3:0] digit_max = 4'h9;
  localparam logic [6:0] tens_weight = 7'h0a;
  typedef enum logic [1:0] {
    path_serial = 2'h0,
    path_fieldbus_class2 = 2'h1,
    path_device_link = 2'h2
  } config_path_type;
  localparam int status_failsafe_bit = 0;
  localparam int status_timeout_bit = 1;
endpackage

// file: shared/safety_link_if.sv
/*
  Telegram link between the safety node and the safety controller.
  Assumes both ends share clk_i; the testbench joins the two modports.
*/
`timescale 1ns/1ps
interface safety_link_if;
  logic ctl_valid;
  logic [79:0] ctl_image;
  logic [15:0] ctl_crc;
  logic [15:0] ctl_source;
  logic [15:0] ctl_dest;
  logic ctl_seq;
  logic node_valid;
  logic [79:0] node_image;
  logic [15:0] node_crc;
  logic node_failsafe;
  logic node_seq;
  modport node(input ctl_valid, ctl_image, ctl_crc, ctl_source, ctl_dest, ctl_seq,
    output node_valid, node_image, node_crc, node_failsafe, node_seq);
  modport controller(output ctl_valid, ctl_image, ctl_crc, ctl_source, ctl_dest, ctl_seq,
    input node_valid, node_image, node_crc, node_failsafe, node_seq);
endinterface

// file: hdl/telegram_watchdog.sv
/*
  Millisecond telegram watchdog shared by both ends.
  Assumes a 100 MHz clock and a restart pulse per valid telegram.
*/
`timescale 1ns/1ps
module telegram_watchdog #(
  parameter int cycles_per_ms = safety_node_pkg::cycles_per_ms
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [15:0] limit_ms_i,
  output logic expired_o
);
  logic [31:0] tick_count;
  logic [15:0] ms_count;
  wire tick = (tick_count == 32'(cycles_per_ms - 1));
  wire at_limit = (ms_count >= limit_ms_i);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart_i || !run_i)
    begin
      tick_count <= 32'h0;
      ms_count <= 16'h0;
    end
    else if (tick)
    begin
      tick_count <= 32'h0;
      if (!at_limit)
        ms_count <= ms_count + 16'h1;
    end
    else
      tick_count <= tick_count + 32'h1;
  end
  // Expiry holds until a valid telegram restarts the count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      expired_o <= 1'b1;
    else if (restart_i)
      expired_o <= 1'b0;
    else if (run_i && at_limit)
      expired_o <= 1'b1;
  end
endmodule

// file: hdl/safety_controller.sv
/*
  Safety controller end: sends addressed telegrams with CRC and supervises
  the node's answers with its own watchdog.
  Assumes the same clock as the node and a user that supplies telegram data.
*/
`timescale 1ns/1ps
module safety_controller #(
  parameter int cycles_per_ms = safety_node_pkg::cycles_per_ms
) (
  input wire logic clk_i,
  input wire logic rst_i,
  safety_link_if.controller link,
  input wire logic send_i,
  input wire logic [79:0] out_image_i,
  input wire logic [15:0] source_address_i,
  input wire logic [15:0] dest_address_i,
  input wire logic sequence_check_option_i,
  input wire logic [15:0] monitor_time_i,
  output logic [79:0] in_image_o,
  output logic failsafe_o
);
  logic expired;
  logic seq_toggle;
  function automatic logic [15:0] crc16(input logic [79:0] image, input logic [15:0] src,
    input logic [15:0] dst, input logic seq, input logic use_seq);
    logic [112:0] data;
    logic [15:0] crc;
    logic fb;
    data = {image, src, dst, use_seq & seq};
    crc = 16'hffff;
    for (int i = 112; i >= 0; i--)
    begin
      fb = crc[15] ^ data[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return crc;
  endfunction
  wire addr_ok = (source_address_i >= safety_node_pkg::safety_address_min) &&
    (source_address_i <= safety_node_pkg::safety_address_max) &&
    (dest_address_i >= safety_node_pkg::safety_address_min) &&
    (dest_address_i <= safety_node_pkg::safety_address_max);
  wire reply_ok = link.node_valid && !link.node_failsafe && (link.node_crc ==
    crc16(link.node_image, dest_address_i, dest_address_i, link.node_seq, sequence_check_option_i));
  telegram_watchdog #(
    .cycles_per_ms(cycles_per_ms)
  ) watchdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .restart_i(reply_ok),
    .limit_ms_i(monitor_time_i),
    .expired_o(expired)
  );
  assign failsafe_o = expired;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link.ctl_valid <= 1'b0;
      link.ctl_image <= 80'h0;
      link.ctl_crc <= 16'h0;
      link.ctl_source <= 16'h0;
      link.ctl_dest <= 16'h0;
      link.ctl_seq <= 1'b0;
      seq_toggle <= 1'b0;
      in_image_o <= 80'h0;
    end
    else
    begin
      link.ctl_valid <= send_i && addr_ok;
      link.ctl_image <= expired ? 80'h0 : out_image_i;
      link.ctl_crc <= crc16(expired ? 80'h0 : out_image_i, source_address_i, dest_address_i, seq_toggle,
        sequence_check_option_i);
      link.ctl_source <= source_address_i;
      link.ctl_dest <= dest_address_i;
      link.ctl_seq <= seq_toggle;
      if (send_i && addr_ok)
        seq_toggle <= !seq_toggle;
      if (expired)
        in_image_o <= 80'h0;
      else if (reply_ok)
        in_image_o <= link.node_image;
    end
  end
endmodule

// file: verif/safety_link_monitor.sv
/*
  Assertions on the telegram link joining the node and the controller.
  Assumes one clock, synchronous active-high reset and a fixed node address.
*/
`timescale 1ns/1ps
module safety_link_monitor #(
  parameter logic [15:0] node_addr = 16'h0005,
  parameter int limit_cycles = 30
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctl_valid,
  input wire logic [15:0] ctl_source,
  input wire logic [15:0] ctl_dest,
  input wire logic node_valid,
  input wire logic [79:0] node_image,
  input wire logic node_failsafe
);
  logic [15:0] quiet_cnt;
  // Counts cycles since the node last answered a telegram.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || node_valid)
    begin
      quiet_cnt <= 16'h0000;
    end
    else if (quiet_cnt != 16'hffff)
    begin
      quiet_cnt <= quiet_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  reply_cause_a: assert property (node_valid |-> $past(ctl_valid))
    else $error("node reply without a request");
  wrong_dest_a: assert property (ctl_valid && ctl_dest != node_addr |=> !node_valid)
    else $error("telegram for another node answered");
  accept_dest_a: assert property (ctl_valid && ctl_dest == node_addr |=> node_valid)
    else $error("telegram for this node not answered");
  addr_range_a: assert property (ctl_valid |-> ctl_source inside {[16'h0001:16'hfffe]}
    && ctl_dest inside {[16'h0001:16'hfffe]})
    else $error("telegram sent with address out of range");
  failsafe_image_a: assert property (node_valid && node_failsafe |-> node_image == 80'h0)
    else $error("failsafe reply carries nonzero image");
  reset_failsafe_a: assert property ($fell(rst_i) |-> node_failsafe)
    else $error("failsafe not active after reset");
  timeout_fs_a: assert property (quiet_cnt > limit_cycles + 3 |-> node_failsafe)
    else $error("failsafe missing after monitor time");
  fs_release_a: assert property ($fell(node_failsafe) |-> quiet_cnt < limit_cycles + 2)
    else $error("failsafe released without fresh telegram");
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> !node_valid && !ctl_valid)
    else $error("link active during reset");
endmodule

// file: verif/tb_top.sv
/*
  Self-checking bench joining the node and the controller over the link.
  Assumes the shared package and interface; the millisecond count is shortened.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int cpm = 10;
  localparam logic [15:0] own = 16'h0005;
  localparam logic [79:0] fin = 80'h0123456789abcdef1122;
  localparam logic [79:0] cout = 80'ha5a50f0f3c3c96967e7e;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] tens = 4'h0;
  logic [3:0] units = 4'h0;
  logic [31:0] wb_adr = 32'h0;
  logic [31:0] wb_wd = 32'h0;
  logic [31:0] wb_rd;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [3:0] sel_val = 4'hf;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_ack;
  logic wb_err;
  logic irq;
  logic [79:0] field_out;
  logic [79:0] in_image;
  logic [6:0] station;
  logic send = 1'b0;
  logic [15:0] src = 16'h0007;
  logic [15:0] dst = own;
  logic seqopt = 1'b0;
  logic ctl_fs;
  logic got;
  logic fs;
  logic [79:0] img;
  logic [31:0] q;
  logic e;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  safety_link_if link();
  safety_node #(.cycles_per_ms(cpm)) safety_node_i (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .switch_tens_i(tens), .switch_units_i(units), .field_image_i(fin), .field_image_o(field_out),
    .station_address_o(station), .wb_adr_i(wb_adr), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack),
    .wb_err_o(wb_err), .irq_o(irq));
  safety_controller #(.cycles_per_ms(cpm)) safety_controller_i (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .send_i(send), .out_image_i(cout), .source_address_i(src), .dest_address_i(dst),
    .sequence_check_option_i(seqopt), .monitor_time_i(16'h0003), .in_image_o(in_image), .failsafe_o(ctl_fs));
  safety_link_monitor #(.node_addr(own), .limit_cycles(3 * cpm)) safety_link_monitor_i (.clk_i(clk_i),
    .rst_i(rst_i), .ctl_valid(link.ctl_valid), .ctl_source(link.ctl_source), .ctl_dest(link.ctl_dest),
    .node_valid(link.node_valid), .node_image(link.node_image), .node_failsafe(link.node_failsafe));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle: hold the request until ack or err is sampled high.
  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= w;
    wb_sel <= sel_val;
    wb_wd <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && wb_err !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = wb_rd;
    e = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  // Sends one telegram and records whether and what the node answered.
  task automatic tel();
    int n;
    n = 0;
    @(posedge clk_i);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    while (link.node_valid !== 1'b1 && n < 5)
    begin
      @(posedge clk_i);
      n++;
    end
    got = link.node_valid;
    img = link.node_image;
    fs = link.node_failsafe;
  endtask
  task automatic t_regs();
    wb(32'h18, 1'b0, 32'h0);
    check(q[10:8], 3'h2);
    wb(32'h18, 1'b1, 32'hff);
    wb(32'h18, 1'b0, 32'h0);
    check(q[7:0], 8'h00);
    wb(32'h00, 1'b0, 32'h0);
    check(q, 32'hffff0004);
    wb(32'h00, 1'b1, 32'h00030000);
    wb(32'h00, 1'b0, 32'h0);
    check(q, 32'hffff0004);
    wb(32'h40, 1'b0, 32'h0);
    check(e, 1'b1);
    wb(32'h04, 1'b1, {16'h0, own});
    wb(32'h04, 1'b1, 32'hffff);
    sel_val = 4'he;
    wb(32'h04, 1'b1, 32'h0009);
    sel_val = 4'hf;
    wb(32'h04, 1'b0, 32'h0);
    check(q[15:0], own);
  endtask
  task automatic t_switch();
    logic [7:0] sw [4] = '{8'h14, 8'h99, 8'h01, 8'h02};
    logic [6:0] st [4] = '{7'h0e, 7'h63, 7'h7e, 7'h02};
    for (int i = 0; i < 4; i++)
    begin
      tens <= sw[i][7:4];
      units <= sw[i][3:0];
      repeat (3) @(posedge clk_i);
      check(station, st[i]);
    end
    tens <= 4'h0;
    units <= 4'h0;
    wb(32'h08, 1'b1, 32'h32);
    wb(32'h08, 1'b1, 32'h02);
    wb(32'h08, 1'b1, 32'h7e);
    repeat (2) @(posedge clk_i);
    check(station, 7'h32);
    wb(32'h14, 1'b1, 32'h1);
    wb(32'h08, 1'b1, 32'h3c);
    wb(32'h00, 1'b1, 32'h00030008);
    wb(32'h00, 1'b0, 32'h0);
    check(q, 32'h00030008);
    check(station, 7'h32);
    wb(32'h14, 1'b1, 32'h12);
    wb(32'h00, 1'b1, 32'h0003000c);
    wb(32'h00, 1'b0, 32'h0);
    check(q, 32'h00030008);
    wb(32'h14, 1'b0, 32'h0);
    check(q, 32'h12);
    wb(32'h14, 1'b1, 32'h0);
    wb(32'h00, 1'b1, 32'h0003000c);
  endtask
  task automatic t_link();
    wb(32'h10, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      tel();
      check(got, 1'b1);
    end
    check(img, fin);
    check(fs, 1'b0);
    check({ctl_fs, in_image}, {1'b0, fin});
    check(field_out, cout);
    dst <= 16'h0006;
    tel();
    check(got, 1'b0);
    dst <= own;
    src <= 16'h0000;
    tel();
    check(got, 1'b0);
    src <= 16'h0007;
    wb(32'h00, 1'b1, 32'h0003000e);
    seqopt <= 1'b1;
    tel();
    check(got, 1'b1);
    wb(32'h00, 1'b1, 32'h0003000d);
    seqopt <= 1'b0;
    tel();
    check({got, fs, img}, {2'b11, 80'h0});
    wb(32'h00, 1'b1, 32'h0003000c);
    tel();
  endtask
  task automatic t_timeout();
    repeat (3 * cpm + 10) @(posedge clk_i);
    check({link.node_failsafe, ctl_fs}, 2'b11);
    check(field_out, 80'h0);
    check(irq, 1'b0);
    wb(32'h10, 1'b1, 32'h2);
    @(posedge clk_i);
    check(irq, 1'b1);
    tel();
    tel();
    check(fs, 1'b0);
    wb(32'h0c, 1'b0, 32'h0);
    check(q[1], 1'b1);
    @(posedge clk_i);
    check(irq, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(station, 7'h00);
    t_regs();
    t_switch();
    t_link();
    t_timeout();
    test_done();
  end
endmodule
